// >>> hw/ccm_defines.svh
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// register byte offsets
`define CCM_OFS_MODE   8'h00
`define CCM_OFS_PCFG   8'h04
`define CCM_OFS_CPL    8'h08
`define CCM_OFS_CPH    8'h0C
`define CCM_OFS_CTRL   8'h10
`define CCM_OFS_STAT   8'h14
`define CCM_OFS_CNT    8'h18

// module mode register fields
`define CCM_MD_WIDE    7
`define CCM_MD_CMP     6
`define CCM_MD_RISE    5
`define CCM_MD_FALL    4
`define CCM_MD_MAT     3
`define CCM_MD_TOG     2
`define CCM_MD_PWM     1
`define CCM_MD_IE      0

// pulse config register fields
`define CCM_PC_ARSEL   7
`define CCM_PC_OVIE    5
`define CCM_PC_CLS_HI  1
`define CCM_PC_CLS_LO  0

// control and status fields
`define CCM_CT_RUN     0
`define CCM_ST_EVT     0
`define CCM_ST_CF      1
`define CCM_ST_SOV     2
`define CCM_ST_PIN     3

// reset values and counter top
`define CCM_RST_MODE   8'h00
`define CCM_RST_PCFG   8'h00
`define CCM_RST_CAP    16'h0000
`define CCM_RST_CNT    16'h0000
`define CCM_CNT_TOP    16'hFFFF

`endif

// >>> hw/ccm_pkg.sv
`default_nettype none
package ccm_pkg;

  typedef enum logic {
    CCM_IDLE = 1'b0,
    CCM_ACC  = 1'b1
  } ccm_apb_st_t;

  typedef enum logic [2:0] {
    CCM_M_OFF, CCM_M_CAP, CCM_M_TIMER, CCM_M_HSO,
    CCM_M_FREQ, CCM_M_PWMS, CCM_M_PWM16
  } ccm_mode_t;

  // low counter bits used by the shared 8/9/10/11-bit cycle length
  function automatic logic [10:0] ccm_len_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   ccm_len_mask = 11'h0FF;
      2'b01:   ccm_len_mask = 11'h1FF;
      2'b10:   ccm_len_mask = 11'h3FF;
      default: ccm_len_mask = 11'h7FF;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> hw/ccm_cnt_if.sv
`default_nettype none
interface ccm_cnt_if;
  logic        run;
  logic        load;
  logic [1:0]  clsel;
  logic [15:0] load_val;
  logic [15:0] count;
  logic        ovf16;
  logic        ovf_short;

  modport ctr (input run, load, clsel, load_val,
               output count, ovf16, ovf_short);
  modport usr (output run, load, clsel, load_val,
               input count, ovf16, ovf_short);
endinterface
`default_nettype wire

// >>> hw/ccm_counter.sv
`include "ccm_defines.svh"
`default_nettype none
module ccm_counter
  import ccm_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // counter link
  ccm_cnt_if.ctr    cif
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [10:0] mask;

  always_comb begin
    cnt_d = cnt_q;
    if (cif.load) begin
      cnt_d = cif.load_val;
    end else if (cif.run) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `CCM_RST_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign mask          = ccm_len_mask(cif.clsel);
  assign cif.count     = cnt_q;
  // overflow is flagged on the last count before the wrap
  assign cif.ovf16     = cif.run & ~cif.load & (cnt_q == `CCM_CNT_TOP);
  assign cif.ovf_short = cif.run & ~cif.load & ((cnt_q[10:0] & mask) == mask);

endmodule
`default_nettype wire

// >>> hw/ccm_edge.sv
`default_nettype none
module ccm_edge (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and edge selection
  input  wire logic pin_i,
  input  wire logic rise_en,
  input  wire logic fall_en,
  // results
  output logic      level,
  output logic      capture
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = pin_i;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign level   = prev_q;
  assign capture = (rise_en & pin_i & ~prev_q) |
                   (fall_en & ~pin_i & prev_q);

endmodule
`default_nettype wire

// >>> hw/ccm_top.sv
// Operation
// - mode bits 5 and 4 pick rising, falling or any edge capture.
// - a qualifying pin edge copies the counter into the capture pair.
// - each capture sets the event flag; request follows if enabled.
// - the event flag stays set until software clears it.
// - pin level stays readable so software can tell the edge.
// - mode bit 0 enables the request from the event flag.
// - comparator off: no toggling, and every pulse mode holds low.
// - config bit 5 enables the short-length overflow request.
// - config bits 1-0 choose 8, 9, 10 or 11-bit pulse length.
// - short pulse modes all use the one shared length setting.
// - config bit 7 steers byte accesses to the reload register, except at 8-bit length.
// - in pulse modes match-flag enable lets matches set the flag.
// - comparator, pulse and wide bits together give 16-bit pulses.
// - 16-bit pulse goes high at match and low at overflow.
// - 16-bit match sets event flag; overflow sets overflow flag.
// - high share is 65536 minus compare, over 65536.
// - low byte write clears comparator enable; high byte sets it.
// - clearing comparator enable forces a fully low 16-bit output.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`include "ccm_defines.svh"
`default_nettype none
module ccm_top
  import ccm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // capture/compare pin
  input  wire logic        capture_compare_pin_i,
  output logic             capture_compare_pin_o,
  output logic             capture_compare_pin_oe_n,
  // requests
  output logic             module_irq,
  output logic             overflow_irq
);

  ccm_cnt_if cif ();

  ccm_apb_st_t st_q, st_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  logic [7:0]  mode_q, mode_d;
  logic [7:0]  pcfg_q, pcfg_d;
  logic [15:0] cap_q, cap_d;
  logic [15:0] arl_q, arl_d;
  logic        run_q, run_d;
  logic        evt_q, evt_d;
  logic        cf_q, cf_d;
  logic        sov_q, sov_d;
  logic        pin_q, pin_d;
  logic        oe_n_q, oe_n_d;
  logic        irq_q, irq_d;
  logic        oirq_q, oirq_d;

  ccm_mode_t   mode_c;
  logic [10:0] mask;
  logic        cmp_en;
  logic        arsel;
  logic        pin_lvl;
  logic        cap_ev;
  logic        m16, m8, msh;
  logic        evt_set;
  logic        err_c;
  logic [31:0] rdata_c;
  logic        wr;
  logic        wr_mode, wr_pcfg, wr_cpl, wr_cph;
  logic        wr_ctrl, wr_stat, wr_cnt;

  ccm_counter u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  ccm_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_i   (capture_compare_pin_i),
    .rise_en (mode_q[`CCM_MD_RISE]),
    .fall_en (mode_q[`CCM_MD_FALL]),
    .level   (pin_lvl),
    .capture (cap_ev)
  );

  // mode decode
  always_comb begin
    mode_c = CCM_M_OFF;
    if ((mode_q[`CCM_MD_RISE] | mode_q[`CCM_MD_FALL]) &
        ~mode_q[`CCM_MD_MAT] & ~mode_q[`CCM_MD_TOG] &
        ~mode_q[`CCM_MD_PWM]) begin
      mode_c = CCM_M_CAP;
    end else if (mode_q[`CCM_MD_PWM] & mode_q[`CCM_MD_WIDE]) begin
      mode_c = CCM_M_PWM16;
    end else if (mode_q[`CCM_MD_PWM] & mode_q[`CCM_MD_TOG]) begin
      mode_c = CCM_M_FREQ;
    end else if (mode_q[`CCM_MD_PWM]) begin
      mode_c = CCM_M_PWMS;
    end else if (mode_q[`CCM_MD_MAT] & mode_q[`CCM_MD_TOG]) begin
      mode_c = CCM_M_HSO;
    end else if (mode_q[`CCM_MD_MAT]) begin
      mode_c = CCM_M_TIMER;
    end
  end

  assign cmp_en = mode_q[`CCM_MD_CMP];
  // shared length from the config register, not per module
  assign mask   = ccm_len_mask(pcfg_q[`CCM_PC_CLS_HI:`CCM_PC_CLS_LO]);
  // 8-bit length ignores the steering bit
  assign arsel  = pcfg_q[`CCM_PC_ARSEL] &
                  (pcfg_q[`CCM_PC_CLS_HI:`CCM_PC_CLS_LO] != 2'b00);

  assign m16 = run_q & (cif.count == cap_q);
  assign m8  = run_q & (cif.count[7:0] == cap_q[7:0]);
  assign msh = run_q & ((cif.count[10:0] & mask) == (cap_q[10:0] & mask));

  // counter link
  assign cif.run      = run_q;
  assign cif.clsel    = pcfg_q[`CCM_PC_CLS_HI:`CCM_PC_CLS_LO];
  assign cif.load     = wr_cnt;
  assign cif.load_val = pwdata[15:0];

  // apb decode and read mux
  always_comb begin
    rdata_c = 32'h0000_0000;
    err_c   = 1'b0;
    case (paddr)
      `CCM_OFS_MODE: rdata_c[7:0] = mode_q;
      `CCM_OFS_PCFG: rdata_c[7:0] = pcfg_q;
      `CCM_OFS_CPL:  rdata_c[7:0] = arsel ? arl_q[7:0] : cap_q[7:0];
      `CCM_OFS_CPH:  rdata_c[7:0] = arsel ? arl_q[15:8] : cap_q[15:8];
      `CCM_OFS_CTRL: rdata_c[`CCM_CT_RUN] = run_q;
      `CCM_OFS_STAT: begin
        rdata_c[`CCM_ST_EVT] = evt_q;
        rdata_c[`CCM_ST_CF]  = cf_q;
        rdata_c[`CCM_ST_SOV] = sov_q;
        rdata_c[`CCM_ST_PIN] = pin_lvl;
      end
      `CCM_OFS_CNT:  rdata_c[15:0] = cif.count;
      default:       err_c = 1'b1;
    endcase
  end

  // writes land at the edge where pready is seen high
  assign wr      = (st_q == CCM_ACC) & psel & penable & pwrite & ~err_c;
  assign wr_mode = wr & (paddr == `CCM_OFS_MODE);
  assign wr_pcfg = wr & (paddr == `CCM_OFS_PCFG);
  assign wr_cpl  = wr & (paddr == `CCM_OFS_CPL);
  assign wr_cph  = wr & (paddr == `CCM_OFS_CPH);
  assign wr_ctrl = wr & (paddr == `CCM_OFS_CTRL);
  assign wr_stat = wr & (paddr == `CCM_OFS_STAT);
  assign wr_cnt  = wr & (paddr == `CCM_OFS_CNT);

  // apb handshake: one wait state on every access
  always_comb begin
    st_d      = st_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    case (st_q)
      CCM_IDLE: begin
        if (psel & penable) begin
          st_d      = CCM_ACC;
          pready_d  = 1'b1;
          pslverr_d = err_c;
          prdata_d  = pwrite ? 32'h0000_0000 : rdata_c;
        end
      end
      CCM_ACC: begin
        st_d = CCM_IDLE;
      end
      default: begin
        st_d = CCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= CCM_IDLE;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // configuration and compare registers
  always_comb begin
    mode_d = mode_q;
    pcfg_d = pcfg_q;
    run_d  = run_q;
    arl_d  = arl_q;
    cap_d  = cap_q;
    if (wr_mode) begin
      mode_d = pwdata[7:0];
    end
    if (wr_pcfg) begin
      pcfg_d = pwdata[7:0];
    end
    if (wr_ctrl) begin
      run_d = pwdata[`CCM_CT_RUN];
    end
    if (wr_cpl) begin
      mode_d[`CCM_MD_CMP] = 1'b0;
    end
    if (wr_cph) begin
      mode_d[`CCM_MD_CMP] = 1'b1;
    end
    // hardware reloads first; a software write in the same cycle wins
    case (mode_c)
      CCM_M_FREQ: begin
        if (cmp_en & m8) begin
          cap_d[7:0] = cap_q[7:0] + cap_q[15:8];
        end
      end
      CCM_M_PWMS: begin
        if (cif.ovf_short) begin
          if (arsel) begin
            cap_d[10:0] = arl_q[10:0];
          end else if (pcfg_q[`CCM_PC_CLS_HI:`CCM_PC_CLS_LO] == 2'b00) begin
            cap_d[7:0] = cap_q[15:8];
          end
        end
      end
      default: begin
      end
    endcase
    if (wr_cpl & arsel) begin
      arl_d[7:0] = pwdata[7:0];
    end else if (wr_cpl) begin
      cap_d[7:0] = pwdata[7:0];
    end
    if (wr_cph & arsel) begin
      arl_d[15:8] = pwdata[7:0];
    end else if (wr_cph) begin
      cap_d[15:8] = pwdata[7:0];
    end
    // a captured count must never be lost to a racing write
    if (mode_c == CCM_M_CAP && cap_ev) begin
      cap_d = cif.count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `CCM_RST_MODE;
      pcfg_q <= `CCM_RST_PCFG;
      run_q  <= 1'b0;
      arl_q  <= `CCM_RST_CAP;
      cap_q  <= `CCM_RST_CAP;
    end else begin
      mode_q <= mode_d;
      pcfg_q <= pcfg_d;
      run_q  <= run_d;
      arl_q  <= arl_d;
      cap_q  <= cap_d;
    end
  end

  // event sources per mode
  always_comb begin
    evt_set = 1'b0;
    case (mode_c)
      CCM_M_CAP:   evt_set = cap_ev;
      CCM_M_TIMER: evt_set = cmp_en & m16;
      CCM_M_HSO:   evt_set = cmp_en & m16;
      CCM_M_FREQ:  evt_set = cmp_en & m8;
      CCM_M_PWMS:  evt_set = cmp_en & mode_q[`CCM_MD_MAT] & msh;
      CCM_M_PWM16: evt_set = cmp_en & mode_q[`CCM_MD_MAT] & m16;
      default:     evt_set = 1'b0;
    endcase
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    evt_d = evt_q;
    cf_d  = cf_q;
    sov_d = sov_q;
    if (wr_stat) begin
      evt_d = evt_q & ~pwdata[`CCM_ST_EVT];
      cf_d  = cf_q & ~pwdata[`CCM_ST_CF];
      sov_d = sov_q & ~pwdata[`CCM_ST_SOV];
    end
    evt_d  = evt_d | evt_set;
    cf_d   = cf_d | cif.ovf16;
    sov_d  = sov_d | cif.ovf_short;
    irq_d  = evt_d & mode_d[`CCM_MD_IE];
    oirq_d = sov_d & pcfg_d[`CCM_PC_OVIE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q  <= 1'b0;
      cf_q   <= 1'b0;
      sov_q  <= 1'b0;
      irq_q  <= 1'b0;
      oirq_q <= 1'b0;
    end else begin
      evt_q  <= evt_d;
      cf_q   <= cf_d;
      sov_q  <= sov_d;
      irq_q  <= irq_d;
      oirq_q <= oirq_d;
    end
  end

  // pin drive; a level compare keeps the duty exact without glitches
  always_comb begin
    pin_d  = pin_q;
    oe_n_d = 1'b0;
    case (mode_c)
      CCM_M_HSO: begin
        if (cmp_en & m16) begin
          pin_d = ~pin_q;
        end
      end
      CCM_M_FREQ: begin
        if (cmp_en & m8) begin
          pin_d = ~pin_q;
        end
      end
      CCM_M_PWMS: begin
        pin_d = cmp_en &
                ((cif.count[10:0] & mask) >= (cap_q[10:0] & mask));
      end
      CCM_M_PWM16: begin
        // high from match to wrap: share is 65536 minus compare
        pin_d = cmp_en & (cif.count >= cap_q);
      end
      default: begin
        pin_d  = 1'b0;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q  <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign capture_compare_pin_o    = pin_q;
  assign capture_compare_pin_oe_n = oe_n_q;
  assign module_irq               = irq_q;
  assign overflow_irq             = oirq_q;

endmodule
`default_nettype wire

// >>> tb/ccm_top_assertions.sv
`include "ccm_defines.svh"
`default_nettype none
module ccm_top_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin and requests
  input wire logic        capture_compare_pin_i,
  input wire logic        capture_compare_pin_o,
  input wire logic        capture_compare_pin_oe_n,
  input wire logic        module_irq,
  input wire logic        overflow_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  md_q;
  logic [7:0]  pc_q;
  logic [15:0] cp_q;
  wire logic   done = psel && penable && pready && pwrite;
  wire logic   bus_wr = psel && pwrite;
  wire logic   ie = md_q[0];
  wire logic   ovie = pc_q[5];
  wire logic   cap_md = md_q[3:1] == 3'b000 && md_q[0];
  // shadow of what software wrote; captures are not tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_q <= `CCM_RST_MODE;
      pc_q <= `CCM_RST_PCFG;
      cp_q <= `CCM_RST_CAP;
    end else if (done) begin
      case (paddr)
        `CCM_OFS_MODE: md_q <= pwdata[7:0];
        `CCM_OFS_PCFG: pc_q <= pwdata[7:0];
        `CCM_OFS_CPL: begin
          cp_q[7:0] <= pwdata[7:0];
          md_q[6] <= 1'b0;
        end
        `CCM_OFS_CPH: begin
          cp_q[15:8] <= pwdata[7:0];
          md_q[6] <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property ($rose(penable) && psel
    |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // every address outside the map is refused, not only those above it
  unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {
    `CCM_OFS_MODE, `CCM_OFS_PCFG, `CCM_OFS_CPL, `CCM_OFS_CPH,
    `CCM_OFS_CTRL, `CCM_OFS_STAT, `CCM_OFS_CNT}))
    else $error("error response does not match address");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  irq_enable_a: assert property (module_irq |-> ie || $past(ie))
    else $error("module request without enable");
  ovf_enable_a: assert property (overflow_irq
    |-> ovie || $past(ovie))
    else $error("overflow request without enable");
  pulse_off_a: assert property ($stable(md_q) && md_q[1]
    && !md_q[2] && !md_q[6] |-> !capture_compare_pin_o)
    else $error("pulse output high with comparator off");
  // toggle alone decodes to no mode, so it must not drive the pin
  pin_drive_a: assert property ($stable(md_q)
    |-> capture_compare_pin_oe_n == !(md_q[1] || (md_q[2] && md_q[3])))
    else $error("pin drive enable wrong for mode");
  full_duty_a: assert property ($stable(md_q)
    && $stable(cp_q) && md_q[7:6] == 2'b11 && md_q[1] && cp_q == 16'h0
    |-> capture_compare_pin_o)
    else $error("zero compare not full duty");
  capture_irq_a: assert property (
    (($rose(capture_compare_pin_i) && md_q[5])
    || ($fell(capture_compare_pin_i) && md_q[4])) && cap_md && $stable(md_q)
    |-> ##[1:4] module_irq)
    else $error("capture edge raised no request");
  flag_hold_a: assert property (module_irq && !bus_wr
    && !$past(bus_wr) |=> module_irq)
    else $error("event flag cleared without software");
  cap_c: cover property (module_irq && cap_md);
  duty_c: cover property ($rose(capture_compare_pin_o) && md_q[7]);
  ovf_c: cover property ($rose(overflow_irq));
  err_c: cover property (pready && pslverr);
endmodule

bind ccm_top ccm_top_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .capture_compare_pin_i(capture_compare_pin_i),
  .capture_compare_pin_o(capture_compare_pin_o),
  .capture_compare_pin_oe_n(capture_compare_pin_oe_n),
  .module_irq(module_irq), .overflow_irq(overflow_irq)
);
`default_nettype wire

// >>> tb/ccm_pin_model.sv
`default_nettype none
module ccm_pin_model (
  // clock
  input  wire logic        pclk,
  // bench request
  input  wire logic        lvl,
  input  wire logic [3:0]  lag,
  input  wire logic        clr,
  // module side of the pin
  input  wire logic        pin_o,
  input  wire logic        oe_n,
  output logic             pin_i,
  output logic [31:0]      high_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_q = 1'b0;
  int   wait_c = 0;
  // the outside source yields the wire while the module drives it
  assign pin_i = oe_n ? ext_q : pin_o;
  // lag lets the source answer promptly or slowly
  always @(posedge pclk) begin
    if (lvl === ext_q) wait_c <= 0;
    else if (wait_c >= lag) begin
      ext_q <= lvl;
      wait_c <= 0;
    end else wait_c <= wait_c + 1;
    if (clr) high_cnt <= 32'h0;
    else if (!oe_n && pin_o) high_cnt <= high_cnt + 1;
  end
endmodule
`default_nettype wire

// >>> tb/tb_counter_array_capture_compare_module.sv
`default_nettype none
module tb_counter_array_capture_compare_module;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic        err;
  } ccm_note_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, hcnt;
  logic        pready, pslverr, pin_i, pin_o, oe_n, mirq, oirq;
  logic        lvl = 1'b0;
  logic        clr = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic [15:0] v, cap;
  logic [7:0]  mt [3] = '{8'h08, 8'h0C, 8'h06};
  ccm_note_t   q [$];
  ccm_note_t   nt;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          seed = 85455;
  int          cyc = 0;
  int          t1, hit;

  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  ccm_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_compare_pin_i(pin_i),
    .capture_compare_pin_o(pin_o), .capture_compare_pin_oe_n(oe_n),
    .module_irq(mirq), .overflow_irq(oirq)
  );
  ccm_pin_model pin (
    .pclk(pclk), .lvl(lvl), .lag(lag), .clr(clr), .pin_o(pin_o),
    .oe_n(oe_n), .pin_i(pin_i), .high_cnt(hcnt)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0, e = 32'h0, m = 32'h0);
    int n;
    n = 0;
    q.push_back({e, m, a > 8'h18});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic clear_hi;
    clr <= 1'b1;
    ticks(1);
    clr <= 1'b0;
  endtask

  task automatic wait_ovf;
    int n;
    n = 0;
    while (oirq !== 1'b0 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    while (oirq !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (oirq !== 1'b1) begin
      error_cnt++;
      final_report();
    end
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        nt = q.pop_front();
        chk(prdata & nt.m, nt.e);
        chk(32'(pslverr), 32'(nt.err));
      end
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({mirq, oirq, oe_n}), 32'h1);
    bus(1, 8'h1C, 32'hFF);
    bus(0, 8'h1C, 32'h0, 32'h0, 32'hFFFF_FFFF);
    bus(0, 8'h00, 32'h0, 32'h0, 32'hFF);
    bus(0, 8'h04, 32'h0, 32'h0, 32'hFF);
    cap = 16'h0;
    // counter left stopped so the captured count is known exactly
    for (int s = 1; s < 4; s++) begin
      bus(1, 8'h00, (s << 4) | 1);
      for (int e = 1; e >= 0; e--) begin
        v = 16'($random(seed));
        bus(1, 8'h18, {16'h0, v});
        bus(1, 8'h14, 32'h7);
        lag <= 4'($random(seed) & 3);
        lvl <= e[0];
        ticks(9);
        hit = e ? s >> 1 : s & 1;
        if (hit != 0) cap = v;
        chk(32'(mirq), hit);
        bus(0, 8'h14, 32'h0, (e << 3) | hit, 32'h9);
        bus(0, 8'h08, 32'h0, 32'(cap[7:0]), 32'hFF);
        bus(0, 8'h0C, 32'h0, 32'(cap[15:8]), 32'hFF);
      end
    end
    bus(1, 8'h00, 32'hCB);
    bus(1, 8'h08, 32'h0);
    bus(0, 8'h00, 32'h0, 32'h8B, 32'hFF);
    ticks(3);
    chk(32'(pin_o), 32'h0);
    bus(1, 8'h0C, 32'h0);
    bus(0, 8'h00, 32'h0, 32'hCB, 32'hFF);
    ticks(3);
    chk(32'(pin_o), 32'h1);
    bus(1, 8'h18, 32'hFE00);
    bus(1, 8'h08, 32'h0);
    bus(1, 8'h0C, 32'hFF);
    bus(1, 8'h14, 32'h7);
    clear_hi();
    bus(1, 8'h10, 32'h1);
    ticks(700);
    bus(1, 8'h10, 32'h0);
    chk(hcnt, 32'h100);
    bus(0, 8'h14, 32'h0, 32'h3, 32'h3);
    chk(32'(mirq), 32'h1);
    // comparator-off cases first, while the pin is still low
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'h18, 32'h0);
      bus(1, 8'h08, 32'h10);
      bus(1, 8'h0C, 32'h0);
      bus(1, 8'h00, {24'h00_0000, mt[i % 3] | (i > 2 ? 8'h40 : 8'h00)});
      bus(1, 8'h14, 32'h7);
      clear_hi();
      bus(1, 8'h10, 32'h1);
      ticks(300);
      bus(1, 8'h10, 32'h0);
      bus(0, 8'h14, 32'h0, 32'(i > 2), 32'h1);
      if (i < 3) chk(hcnt, 32'h0);
    end
    // interval between two wraps hides the request latency
    for (int c = 0; c < 4; c++) begin
      bus(1, 8'h04, 32'h20 | c);
      bus(1, 8'h00, 32'h4A);
      bus(1, 8'h18, 32'h0);
      bus(1, 8'h14, 32'h7);
      bus(1, 8'h10, 32'h1);
      wait_ovf();
      t1 = cyc;
      bus(1, 8'h14, 32'h7);
      wait_ovf();
      chk(cyc - t1, 256 << c);
      bus(0, 8'h14, 32'h0, 32'h1, 32'h1);
      bus(1, 8'h10, 32'h0);
    end
    // steered byte writes reach the reload word and spare the compare
    bus(1, 8'h04, 32'h81);
    bus(1, 8'h08, 32'h5A);
    bus(0, 8'h08, 32'h0, 32'h5A, 32'hFF);
    bus(1, 8'h04, 32'h01);
    bus(0, 8'h08, 32'h0, 32'h0, 32'hFF);
    final_report();
  end
endmodule
`default_nettype wire
